// ===== ptc_pll_tuner_control.sv
`timescale 1ns/1ps
module ptc_pll_tuner_control
#(
  parameter bit WIDE_VARIANT = 1'b1
)
(
  input  wire logic       clk_i,                 // System clock, 200 MHz
  input  wire logic       rst_i,                 // Synchronous reset
  input  wire logic       ce_i,                  // Clock enable
  input  wire logic       lo_clk_i,              // Prescaled oscillator clock
  input  wire logic       xtal_i,                // Crystal clock pin
  input  wire logic       scl_i,                 // Serial bus clock pin
  input  wire logic       sda_i,                 // Serial bus data pin level
  output logic            sda_o,                 // Serial data drive value
  output logic            sda_oe_o,              // Serial data drive enable
  input  wire logic [1:0] addr_select_pin_i,     // Strap level, encoded
  output logic            band_out_zero_n_o,     // Band output, low is on
  output logic            band_out_one_n_o,      // Band output, low is on
  output logic            band_out_two_n_o,      // Band output, low is on
  output logic            band_out_four_n_o,     // Band output, low is on
  output logic            band_out_seven_n_o,    // Band output, low is on
  output logic            amp_output_off_o,      // Amplifier stage off
  output logic            pump_current_high_o,   // High pump current
  output logic            pump_up_o,             // Upper source on
  output logic            pump_down_o            // Lower source on
);
  logic [4:0]                  async_in;
  logic [4:0]                  meta_reg;
  logic [4:0]                  sync_reg;
  logic [2:0]                  hist_reg;
  logic                        scl_s;
  logic                        sda_s;
  logic                        xtal_s;
  logic [1:0]                  ca_s;
  logic                        scl_rise;
  logic                        scl_fall;
  logic                        start_det;
  logic                        stop_det;
  logic                        xtal_rise;
  ptc_pkg::ptc_rx_state_t      state_reg;
  ptc_pkg::ptc_rx_state_t      state_next;
  logic [3:0]                  bit_cnt_reg;
  logic [3:0]                  bit_cnt_next;
  logic [7:0]                  shift_reg;
  logic [7:0]                  shift_next;
  logic [2:0]                  byte_cnt_reg;
  logic [2:0]                  byte_cnt_next;
  logic [7:0]                  first_reg;
  logic [7:0]                  first_next;
  logic                        sda_oe_reg;
  logic                        sda_oe_next;
  logic [7:0]                  setup_reg;
  logic [7:0]                  setup_next;
  logic [7:0]                  band_reg;
  logic [7:0]                  band_next;
  logic [14:0]                 latch_a_reg;
  logic [14:0]                 latch_a_next;
  logic                        freq_wr;
  logic                        byte_accept;
  logic                        want_reg;
  logic                        xfer_req_reg;
  logic [14:0]                 xfer_word_reg;
  logic                        issue;
  logic                        busy;
  logic                        ack_tgl;
  logic                        half_tgl;
  logic [1:0]                  ack_meta_reg;
  logic [1:0]                  ack_sync_reg;
  logic                        half_prev_reg;
  logic                        div_tick;
  logic [9:0]                  ref_cnt_reg;
  logic [9:0]                  ref_term;
  logic [9:0]                  ref_half;
  logic                        ref_tick;
  logic                        ref_wave_reg;
  logic                        long_ratio;
  logic                        up_reg;
  logic                        dn_reg;
  logic                        up_hold;
  logic                        dn_hold;
  logic                        up_next;
  logic                        dn_next;
  ptc_pkg::ptc_cmp_mode_t      cmp_mode;
  logic                        test_on;
  logic                        pump_up_next;
  logic                        pump_dn_next;

  function automatic logic [7:0] chip_addr(input logic [1:0] sel);
    case (sel)
      2'h0:    chip_addr = ptc_pkg::CHIP_ADDR_0;
      2'h1:    chip_addr = ptc_pkg::CHIP_ADDR_1;
      2'h2:    chip_addr = ptc_pkg::CHIP_ADDR_2;
      default: chip_addr = ptc_pkg::CHIP_ADDR_3;
    endcase
  endfunction

  // Open-collector level for one band: low while its bit is one and the band is present
  function automatic logic band_level(input logic bit_on, input logic present);
    band_level = ~(bit_on & present);
  endfunction

  // Pin synchronisers, then one history stage for edge detection
  assign async_in = {addr_select_pin_i, xtal_i, scl_i, sda_i};
  assign sda_s = sync_reg[0];
  assign scl_s = sync_reg[1];
  assign xtal_s = sync_reg[2];
  assign ca_s = sync_reg[4:3];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= ptc_pkg::SYNC_RESET;
      sync_reg <= ptc_pkg::SYNC_RESET;
      hist_reg <= ptc_pkg::HIST_RESET;
    end
    else if (ce_i)
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      hist_reg <= sync_reg[2:0];
    end
  end

  assign scl_rise = scl_s & ~hist_reg[1];
  assign scl_fall = ~scl_s & hist_reg[1];
  assign start_det = scl_s & hist_reg[1] & hist_reg[0] & ~sda_s;
  assign stop_det = scl_s & hist_reg[1] & ~hist_reg[0] & sda_s;
  assign xtal_rise = xtal_s & ~hist_reg[2];

  // Address byte must match the strap-selected write address
  assign byte_accept = (byte_cnt_reg == ptc_pkg::ADDR_BYTE) ?
                       (shift_reg == chip_addr(ca_s)) : 1'b1;

  always_comb
  begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    byte_cnt_next = byte_cnt_reg;
    first_next = first_reg;
    sda_oe_next = sda_oe_reg;
    setup_next = setup_reg;
    band_next = band_reg;
    latch_a_next = latch_a_reg;
    freq_wr = 1'b0;
    if (start_det)
    begin
      state_next = ptc_pkg::PTC_ST_RECV;
      bit_cnt_next = 4'h0;
      byte_cnt_next = ptc_pkg::ADDR_BYTE;
      sda_oe_next = 1'b0;
    end
    else if (stop_det)
    begin
      state_next = ptc_pkg::PTC_ST_IDLE;
      sda_oe_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        ptc_pkg::PTC_ST_IDLE:
        begin
          state_next = ptc_pkg::PTC_ST_IDLE;
        end
        ptc_pkg::PTC_ST_RECV:
        begin
          if (scl_rise && bit_cnt_reg != ptc_pkg::BITS_PER_BYTE)
          begin
            shift_next = {shift_reg[6:0], sda_s};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end
          else if (scl_fall && bit_cnt_reg == ptc_pkg::BITS_PER_BYTE)
          begin
            if (byte_accept)
            begin
              state_next = ptc_pkg::PTC_ST_ACK;
              sda_oe_next = 1'b1;
            end
            else
            begin
              state_next = ptc_pkg::PTC_ST_IGNORE;
            end
          end
        end
        ptc_pkg::PTC_ST_ACK:
        begin
          if (scl_fall)
          begin
            sda_oe_next = 1'b0;
            bit_cnt_next = 4'h0;
            byte_cnt_next = byte_cnt_reg + 3'h1;
            state_next = ptc_pkg::PTC_ST_RECV;
            if (byte_cnt_reg[0])
            begin
              first_next = shift_reg;
            end
            else if (byte_cnt_reg != ptc_pkg::ADDR_BYTE)
            begin
              if (first_reg[ptc_pkg::FUNC_FLAG_BIT])
              begin
                setup_next = first_reg;
                band_next = shift_reg;
              end
              else
              begin
                latch_a_next = {first_reg[6:0], shift_reg};
                freq_wr = 1'b1;
              end
            end
            if (byte_cnt_reg == ptc_pkg::LAST_ACKED_BYTE)
            begin
              state_next = ptc_pkg::PTC_ST_IGNORE;
            end
          end
        end
        ptc_pkg::PTC_ST_IGNORE:
        begin
          state_next = ptc_pkg::PTC_ST_IGNORE;
        end
        default:
        begin
          state_next = ptc_pkg::PTC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= ptc_pkg::PTC_ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      byte_cnt_reg <= ptc_pkg::ADDR_BYTE;
      first_reg <= 8'h00;
      sda_oe_reg <= 1'b0;
      setup_reg <= ptc_pkg::SETUP_RESET;
      band_reg <= ptc_pkg::BAND_RESET;
      latch_a_reg <= ptc_pkg::DIV_RESET;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      byte_cnt_reg <= byte_cnt_next;
      first_reg <= first_next;
      sda_oe_reg <= sda_oe_next;
      setup_reg <= setup_next;
      band_reg <= band_next;
      latch_a_reg <= latch_a_next;
    end
  end

  // Transfer handshake toward the divider domain; word held until taken
  assign busy = xfer_req_reg != ack_sync_reg[0];
  assign issue = want_reg & ~busy;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      want_reg <= 1'b0;
      xfer_req_reg <= 1'b0;
      xfer_word_reg <= ptc_pkg::DIV_RESET;
      ack_meta_reg <= 2'h0;
      ack_sync_reg <= 2'h0;
      half_prev_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      want_reg <= start_det | freq_wr | (want_reg & ~issue);
      if (issue)
      begin
        xfer_req_reg <= ~xfer_req_reg;
        xfer_word_reg <= latch_a_reg;
      end
      ack_meta_reg <= {half_tgl, ack_tgl};
      ack_sync_reg <= ack_meta_reg;
      half_prev_reg <= ack_sync_reg[1];
    end
  end

  assign div_tick = ack_sync_reg[1] ^ half_prev_reg;

  ptc_divider u_divider
  (
    .lo_clk_i    (lo_clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .latch_a_i   (xfer_word_reg),
    .xfer_req_i  (xfer_req_reg),
    .xfer_ack_o  (ack_tgl),
    .half_tick_o (half_tgl)
  );

  // Reference divider on crystal rising edges
  assign long_ratio = setup_reg[ptc_pkg::RATIO_FIRST_BIT] ^ setup_reg[ptc_pkg::RATIO_SECOND_BIT];
  assign ref_term = long_ratio ? ptc_pkg::REF_TERM_LONG : ptc_pkg::REF_TERM_SHORT;
  assign ref_half = long_ratio ? ptc_pkg::REF_HALF_LONG : ptc_pkg::REF_HALF_SHORT;
  assign ref_tick = xtal_rise & (ref_cnt_reg >= ref_term);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_cnt_reg <= 10'h000;
      ref_wave_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (ref_tick)
      begin
        ref_cnt_reg <= 10'h000;
      end
      else if (xtal_rise)
      begin
        ref_cnt_reg <= ref_cnt_reg + 10'h001;
      end
      ref_wave_reg <= ref_cnt_reg < ref_half;
    end
  end

  // Three-state phase/frequency detector
  assign up_hold = up_reg | ref_tick;
  assign dn_hold = dn_reg | div_tick;
  assign up_next = up_hold & ~dn_hold;
  assign dn_next = dn_hold & ~up_hold;
  assign cmp_mode = ptc_pkg::ptc_cmp_mode_t'({setup_reg[ptc_pkg::CMP_HI_BIT], setup_reg[ptc_pkg::CMP_LO_BIT]});
  assign test_on = setup_reg[ptc_pkg::TEST_BIT];

  always_comb
  begin
    case (cmp_mode)
      ptc_pkg::PTC_CMP_NORMAL:
      begin
        pump_up_next = up_next;
        pump_dn_next = dn_next;
      end
      ptc_pkg::PTC_CMP_UPPER:
      begin
        pump_up_next = 1'b1;
        pump_dn_next = 1'b0;
      end
      ptc_pkg::PTC_CMP_LOWER:
      begin
        pump_up_next = 1'b0;
        pump_dn_next = 1'b1;
      end
      default:
      begin
        pump_up_next = 1'b0;
        pump_dn_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
      pump_up_o <= 1'b0;
      pump_down_o <= 1'b0;
      pump_current_high_o <= 1'b0;
      amp_output_off_o <= 1'b0;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
      up_reg <= up_next;
      dn_reg <= dn_next;
      pump_up_o <= pump_up_next;
      pump_down_o <= pump_dn_next;
      pump_current_high_o <= setup_reg[ptc_pkg::PUMP_BIT];
      amp_output_off_o <= setup_reg[ptc_pkg::AMP_OFF_BIT];
      sda_o <= 1'b0;
      sda_oe_o <= sda_oe_reg;
    end
  end

  // Band outputs; test mode routes internal ticks onto bands seven and two
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      band_out_zero_n_o <= 1'b1;
      band_out_one_n_o <= 1'b1;
      band_out_two_n_o <= 1'b1;
      band_out_four_n_o <= 1'b1;
      band_out_seven_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      band_out_zero_n_o <= band_level(band_reg[ptc_pkg::BAND_ZERO_BIT], WIDE_VARIANT);
      band_out_one_n_o <= band_level(band_reg[ptc_pkg::BAND_ONE_BIT], 1'b1);
      band_out_four_n_o <= band_level(band_reg[ptc_pkg::BAND_FOUR_BIT], WIDE_VARIANT);
      if (test_on)
      begin
        band_out_seven_n_o <= ref_wave_reg;
        band_out_two_n_o <= ack_sync_reg[1];
      end
      else
      begin
        band_out_seven_n_o <= band_level(band_reg[ptc_pkg::BAND_SEVEN_BIT], 1'b1);
        band_out_two_n_o <= band_level(band_reg[ptc_pkg::BAND_TWO_BIT], 1'b1);
      end
    end
  end
endmodule

// ===== ptc_pkg.sv
package ptc_pkg;
  localparam logic [7:0]  CHIP_ADDR_0 = 8'hc0;
  localparam logic [7:0]  CHIP_ADDR_1 = 8'hc2;
  localparam logic [7:0]  CHIP_ADDR_2 = 8'hc4;
  localparam logic [7:0]  CHIP_ADDR_3 = 8'hc6;
  localparam int          FUNC_FLAG_BIT = 7;
  localparam int          PUMP_BIT = 6;
  localparam int          TEST_BIT = 5;
  localparam int          CMP_LO_BIT = 4;
  localparam int          RATIO_SECOND_BIT = 3;
  localparam int          RATIO_FIRST_BIT = 2;
  localparam int          CMP_HI_BIT = 1;
  localparam int          AMP_OFF_BIT = 0;
  localparam int          BAND_SEVEN_BIT = 7;
  localparam int          BAND_FOUR_BIT = 4;
  localparam int          BAND_TWO_BIT = 2;
  localparam int          BAND_ONE_BIT = 1;
  localparam int          BAND_ZERO_BIT = 0;
  localparam int          DIV_W = 15;
  localparam logic [14:0] DIV_RESET = 15'h0100;
  localparam logic [14:0] DIV_TERM = 15'h0001;
  localparam logic [7:0]  SETUP_RESET = 8'h82;
  localparam logic [7:0]  BAND_RESET = 8'h00;
  localparam logic [9:0]  REF_TERM_SHORT = 10'h1ff;
  localparam logic [9:0]  REF_TERM_LONG = 10'h3ff;
  localparam logic [9:0]  REF_HALF_SHORT = 10'h100;
  localparam logic [9:0]  REF_HALF_LONG = 10'h200;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [2:0]  ADDR_BYTE = 3'h0;
  localparam logic [2:0]  LAST_ACKED_BYTE = 3'h4;
  localparam logic [4:0]  SYNC_RESET = 5'h03;
  localparam logic [2:0]  HIST_RESET = 3'h3;

  typedef enum logic [1:0]
  {
    PTC_ST_IDLE   = 2'b00,
    PTC_ST_RECV   = 2'b01,
    PTC_ST_ACK    = 2'b11,
    PTC_ST_IGNORE = 2'b10
  } ptc_rx_state_t;

  // Encoded as {comparator_mode_hi, comparator_mode_lo}
  typedef enum logic [1:0]
  {
    PTC_CMP_UPPER  = 2'b00,
    PTC_CMP_LOWER  = 2'b01,
    PTC_CMP_NORMAL = 2'b10,
    PTC_CMP_HIZ    = 2'b11
  } ptc_cmp_mode_t;
endpackage

// ===== ptc_divider.sv
`timescale 1ns/1ps
module ptc_divider
(
  input  wire logic        lo_clk_i,    // Prescaled oscillator clock
  input  wire logic        rst_i,       // Reset from main domain
  input  wire logic        ce_i,        // Clock enable from main domain
  input  wire logic [14:0] latch_a_i,   // Held word, stable while request open
  input  wire logic        xfer_req_i,  // Transfer request toggle
  output logic             xfer_ack_o,  // Transfer taken toggle
  output logic             half_tick_o  // Divider output divided by two
);
  logic [2:0]  meta_reg;
  logic [2:0]  sync_reg;
  logic        rst_s;
  logic        ce_s;
  logic        req_s;
  logic        ack_reg;
  logic        half_reg;
  logic        pending_reg;
  logic        pending_next;
  logic [14:0] stage_reg;
  logic [14:0] latch_b_reg;
  logic [14:0] cnt_reg;
  logic        capture;
  logic        terminal;

  assign rst_s = sync_reg[2];
  assign ce_s = sync_reg[1];
  assign req_s = sync_reg[0];
  assign capture = req_s != ack_reg;
  assign terminal = cnt_reg <= ptc_pkg::DIV_TERM;
  assign pending_next = capture | (pending_reg & ~terminal);

  always_ff @(posedge lo_clk_i)
  begin
    meta_reg <= {rst_i, ce_i, xfer_req_i};
    sync_reg <= meta_reg;
  end

  always_ff @(posedge lo_clk_i)
  begin
    if (rst_s)
    begin
      ack_reg <= 1'b0;
      half_reg <= 1'b0;
      pending_reg <= 1'b0;
      stage_reg <= ptc_pkg::DIV_RESET;
      latch_b_reg <= ptc_pkg::DIV_RESET;
      cnt_reg <= ptc_pkg::DIV_RESET;
    end
    else if (ce_s)
    begin
      pending_reg <= pending_next;
      if (capture)
      begin
        stage_reg <= latch_a_i;
        ack_reg <= req_s;
      end
      if (terminal)
      begin
        half_reg <= ~half_reg;
        if (pending_reg)
        begin
          latch_b_reg <= stage_reg;
          cnt_reg <= stage_reg;
        end
        else
        begin
          cnt_reg <= latch_b_reg;
        end
      end
      else
      begin
        cnt_reg <= cnt_reg - 15'h0001;
      end
    end
  end

  assign xfer_ack_o = ack_reg;
  assign half_tick_o = half_reg;
endmodule

// ===== ptc_props.sv
`timescale 1ns/1ps
module ptc_props
#(
  parameter bit WIDE_VARIANT = 1'b1
)
(
  input wire logic       clk_i,               // Clock
  input wire logic       rst_i,               // Reset
  input wire logic       ce_i,                // Enable
  input wire logic       lo_clk_i,            // Divider clock
  input wire logic       xtal_i,              // Crystal
  input wire logic       scl_i,               // Bus clock
  input wire logic       sda_i,               // Bus data
  input wire logic       sda_o,               // Data value
  input wire logic       sda_oe_o,            // Data enable
  input wire logic [1:0] addr_select_pin_i,   // Strap
  input wire logic       band_out_zero_n_o,   // Band
  input wire logic       band_out_one_n_o,    // Band
  input wire logic       band_out_two_n_o,    // Band
  input wire logic       band_out_four_n_o,   // Band
  input wire logic       band_out_seven_n_o,  // Band
  input wire logic       amp_output_off_o,    // Amplifier off
  input wire logic       pump_current_high_o, // Pump current
  input wire logic       pump_up_o,           // Upper source
  input wire logic       pump_down_o          // Lower source
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_scl_fall;
    $fell(scl_i);
  endsequence

  a_reset_outputs_off:
    assert property (disable iff (1'b0) rst_i |=> band_out_zero_n_o && band_out_one_n_o && band_out_two_n_o
      && band_out_four_n_o && band_out_seven_n_o && !amp_output_off_o && !pump_current_high_o && !pump_up_o
      && !pump_down_o && !sda_oe_o)
    else $error("outputs not at reset values");
  a_ack_pulls_low:
    assert property (sda_oe_o |-> !sda_o) else $error("acknowledge drives data high");
  a_ack_starts_low:
    assert property ($rose(sda_oe_o) |-> !$past(scl_i, 2)) else $error("acknowledge starts with clock high");
  a_ack_ends_low:
    assert property ($fell(sda_oe_o) |-> !$past(scl_i, 2)) else $error("acknowledge ends with clock high");
  a_ack_slot_stands:
    assert property ($rose(sda_oe_o) |-> sda_oe_o[*8]) else $error("acknowledge too short");
  a_ack_slot_ends:
    assert property (sda_oe_o ##0 s_scl_fall |-> ##[1:8] !sda_oe_o) else $error("acknowledge not released");
  a_setting_change_low:
    assert property ($changed(band_out_one_n_o) || $changed(amp_output_off_o) || $changed(pump_current_high_o)
      |-> !$past(scl_i, 2))
    else $error("setting changed outside an acknowledge");
  a_reduced_bands_off:
    assert property (!WIDE_VARIANT |-> band_out_zero_n_o && band_out_four_n_o) else $error("missing band driven");
  a_pumps_not_both:
    assert property (pump_up_o && pump_down_o |=> !(pump_up_o && pump_down_o)) else $error("both sources held on");
endmodule

// ===== ptc_bus_master.sv
`timescale 1ns/1ps
module ptc_bus_master
#(
  parameter int HALF = 12
)
(
  input  wire logic clk_i,    // Bench clock
  input  wire logic sda_i,    // Resolved data line
  output logic      scl_o,    // Bus clock, idles high
  output logic      sda_low_o // High pulls data low
);
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Data moves a few cycles after the clock falls so it never looks like a start or stop
  task automatic start_c();
    wait_n(HALF);
    sda_low_o = 1'b1;
    wait_n(HALF);
    scl_o = 1'b0;
    wait_n(3);
  endtask

  task automatic bit_c(input logic b, output logic seen);
    sda_low_o = !b;
    wait_n(HALF);
    scl_o = 1'b1;
    wait_n(HALF);
    seen = sda_i;
    scl_o = 1'b0;
    wait_n(3);
  endtask

  task automatic wr(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_c(b[i], s);
    bit_c(1'b1, s);
    ack = (s === 1'b0);
  endtask

  task automatic stop_c();
    sda_low_o = 1'b1;
    wait_n(HALF);
    scl_o = 1'b1;
    wait_n(HALF);
    sda_low_o = 1'b0;
    wait_n(HALF);
  endtask
endmodule

// ===== ptc_pll_tuner_control_tb_top.sv
`timescale 1ns/1ps
module ptc_pll_tuner_control_tb_top;
  logic        clk_i = 1'b0;
  logic        lo_clk_i = 1'b0;
  logic        xtal_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce = 1'b1;
  logic [1:0]  strap = 2'h0;
  logic        scl;
  logic        m_sda_low;
  logic        sda_line;
  logic        sda_o;
  logic        sda_oe_o;
  logic        sda_o2;
  logic        sda_oe2;
  logic [4:0]  band_n;   // Seven, four, two, one, zero
  logic [4:0]  band2_n;
  logic        amp;
  logic        pump;
  logic        up;
  logic        down;
  int          err_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [15:0] exp_q[$];
  logic [15:0] seen_q[$];
  event        posted;

  always #2.5 clk_i = ~clk_i;
  always #32 lo_clk_i = ~lo_clk_i;
  initial
  begin
    #1.3;
    forever #20 xtal_i = ~xtal_i;
  end

  // Pull-up on the data line; any driver pulls it low
  assign sda_line = !(m_sda_low || (sda_oe_o && !sda_o) || (sda_oe2 && !sda_o2));

  ptc_bus_master #(.HALF(12)) u_master (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_low_o(m_sda_low));

  ptc_pll_tuner_control #(.WIDE_VARIANT(1'b1)) u_dut
  (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .lo_clk_i(lo_clk_i), .xtal_i(xtal_i), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_select_pin_i(strap),
    .band_out_zero_n_o(band_n[0]), .band_out_one_n_o(band_n[1]), .band_out_two_n_o(band_n[2]),
    .band_out_four_n_o(band_n[3]), .band_out_seven_n_o(band_n[4]), .amp_output_off_o(amp),
    .pump_current_high_o(pump), .pump_up_o(up), .pump_down_o(down)
  );

  ptc_pll_tuner_control #(.WIDE_VARIANT(1'b0)) u_dut_reduced
  (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .lo_clk_i(lo_clk_i), .xtal_i(xtal_i), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o2), .sda_oe_o(sda_oe2), .addr_select_pin_i(strap),
    .band_out_zero_n_o(band2_n[0]), .band_out_one_n_o(band2_n[1]), .band_out_two_n_o(band2_n[2]),
    .band_out_four_n_o(band2_n[3]), .band_out_seven_n_o(band2_n[4]), .amp_output_off_o(),
    .pump_current_high_o(), .pump_up_o(), .pump_down_o()
  );

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic post(input logic [15:0] seen, input logic [15:0] exp);
    seen_q.push_back(seen);
    exp_q.push_back(exp);
    -> posted;
  endtask

  always @(posted)
    while (seen_q.size() > 0)
      check(seen_q.pop_front(), exp_q.pop_front());

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      err_count++;
      $display("ERROR %0t: run did not finish", $time);
      summarize();
    end
  end

  task automatic msg(input logic [7:0] b[$], input bit hit);
    logic ack;
    u_master.start_c();
    foreach (b[i])
    begin
      u_master.wr(b[i], ack);
      post({15'h0, ack}, {15'h0, hit && i < 5});
    end
    u_master.stop_c();
  endtask

  // Clock cycles between two rising edges of band seven or band two
  task automatic meas(input bit sel, output int cyc);
    int   rises;
    logic prev;
    logic cur;
    rises = 0;
    cyc = 0;
    prev = 1'b1;
    while (rises < 2)
    begin
      @(posedge clk_i);
      #1;
      cur = sel ? band_n[4] : band_n[2];
      if (cur === 1'b1 && prev === 1'b0)
        rises++;
      if (rises == 1)
        cyc++;
      prev = cur;
    end
  endtask

  initial
  begin
    logic [7:0] ctrl;
    logic [7:0] band;
    logic [1:0] mode;
    int         cyc;
    void'($urandom(60925));
    repeat (5) @(posedge lo_clk_i);
    @(posedge clk_i);
    #1 rst_i = 1'b0;
    @(posedge clk_i);
    #1 post({6'h0, band_n, amp, pump, up, down, sda_oe_o}, 16'h03e0);
    repeat (10) @(posedge clk_i);
    #1;
    $display("test reset done");
    for (int a = 0; a < 4; a++)
    begin
      strap = a[1:0];
      repeat (4) @(posedge clk_i);
      msg('{{5'h18, a[1:0], 1'b0}, 8'h82, 8'h00}, 1'b1);
      msg('{{5'h18, a[1:0] + 2'h1, 1'b0}, 8'h82, 8'h00}, 1'b0);
    end
    $display("test address done");
    for (int k = 0; k < 4; k++)
    begin
      mode = k[1:0];
      ctrl = (8'($urandom) & 8'h4d) | 8'h80 | {3'h0, mode[0], 2'h0, mode[1], 1'b0};
      band = 8'($urandom) | {3'h0, k[0], 3'h0, k[0]};
      msg('{8'hc6, ctrl, band}, 1'b1);
      post({7'h0, band_n, amp, pump, (mode == 2'b10) ? 2'b00 : {up, down}}, {7'h0,
        ~{band[7], band[4], band[2], band[1], band[0]}, ctrl[0], ctrl[6],
        (mode == 2'b00) ? 2'b10 : {1'b0, mode == 2'b01}});
      post({14'h0, band2_n[3], band2_n[0]}, 16'h0003);
    end
    // Clock enable low: bus ignored, settings frozen
    ce = 1'b0;
    msg('{8'hc6, 8'h82, 8'h00}, 1'b0);
    post({14'h0, amp, pump}, {14'h0, ctrl[0], ctrl[6]});
    ce = 1'b1;
    msg('{8'hc6, 8'h82, 8'h00, 8'hc1}, 1'b1);
    post({14'h0, amp, pump}, 16'h0000);
    $display("test control done");
    // Ratio 17, test routing on, band two and seven written off, sixth byte refused
    msg('{8'hc6, 8'h00, 8'h11, 8'ha2, 8'h00, 8'hff}, 1'b1);
    repeat (4000) @(posedge clk_i);
    meas(1'b0, cyc);
    post({15'h0, cyc >= 434 && cyc <= 437}, 16'h0001);
    meas(1'b1, cyc);
    post({15'h0, cyc >= 4094 && cyc <= 4098}, 16'h0001);
    msg('{8'hc6, 8'ha6, 8'h00}, 1'b1);
    meas(1'b1, cyc);
    meas(1'b1, cyc);
    post({15'h0, cyc >= 8190 && cyc <= 8194}, 16'h0001);
    $display("test divider done");
    @(posedge clk_i);
    summarize();
  end
endmodule

bind ptc_pll_tuner_control ptc_props #(.WIDE_VARIANT(WIDE_VARIANT)) u_props
(
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .lo_clk_i(lo_clk_i), .xtal_i(xtal_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_select_pin_i(addr_select_pin_i),
  .band_out_zero_n_o(band_out_zero_n_o), .band_out_one_n_o(band_out_one_n_o),
  .band_out_two_n_o(band_out_two_n_o), .band_out_four_n_o(band_out_four_n_o),
  .band_out_seven_n_o(band_out_seven_n_o), .amp_output_off_o(amp_output_off_o),
  .pump_current_high_o(pump_current_high_o), .pump_up_o(pump_up_o), .pump_down_o(pump_down_o)
);
